// file: eera_top.sv
// EEPROM register front end on the core's data memory bus
// Operation
// [RULE_01] Index and value registers direct in bank 0
// [RULE_02] Control register only via indirect port
// [RULE_03] Program sets pointer 40H, bank 01H first
// [RULE_04] Index holds six bits, top two read zero
// [RULE_05] Value register is full eight bit read/write
// [RULE_06] Program sets store permit before any write
// [RULE_07] Store permit low blocks every write
// [RULE_08] Store trigger one starts a write cycle
// [RULE_09] Hardware clears store trigger when write ends
// [RULE_10] Store trigger ignored unless permit already set
// [RULE_11] Program sets fetch permit before any read
// [RULE_12] Fetch permit low blocks every read
// [RULE_13] Fetch trigger one starts a read cycle
// [RULE_14] Hardware clears fetch trigger when read ends
// [RULE_15] Fetch trigger ignored unless permit already set
// [RULE_16] Program never sets permits and triggers together
// [RULE_17] Program never requests read and write together
// [RULE_18] Fetched byte stays until next operation
// [RULE_19] Array holds 64 bytes, index 00H to 3FH
// [RULE_20] Write time set by independent internal timer
// [RULE_21] Cycle end sets done flag, cleared explicitly
// [RULE_22] Both triggers in one write are ignored
`timescale 1ns/1ps
module eera_top #(
  parameter int TICK_DIV = eera_pkg::TIMER_DIV_CYCLES,
  parameter int WRITE_TICKS = eera_pkg::WRITE_TIME_TICKS
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire eera_pkg::eera_dm_req_t req_i,
  input wire logic nv_done_clr_i,
  output logic [7:0] rdata_o,
  output logic nv_done_flag_o
);
  import eera_pkg::*;

  logic bank_select, next_bank_select;
  logic [7:0] indirect_pointer_one, next_pointer;
  logic [5:0] cell_index_reg, next_index;
  logic [7:0] cell_value_reg, next_value;
  logic [3:0] cell_control_reg, next_control;
  logic next_done_flag;
  logic [7:0] next_rdata;
  logic via_port;
  logic [7:0] eff_addr;
  logic sel_bank, sel_pointer, sel_index, sel_value, sel_control;
  logic ctrl_we, both_trig, trig_idle;
  logic store_go, fetch_go, store_done, fetch_done;
  logic [7:0] fetch_data;
  eera_cell_cmd_t cell_cmd;

  // Address decode; the port address redirects through the pointer
  assign via_port = (req_i.addr == INDIRECT_PORT_ADDR);
  assign eff_addr = via_port ? indirect_pointer_one : req_i.addr;
  assign sel_bank = !via_port && (req_i.addr == BANK_SEL_ADDR);
  assign sel_pointer = !via_port && (req_i.addr == INDIRECT_PTR_ADDR);
  // [RULE_01] Bank 0 direct decode
  assign sel_index = (eff_addr == CELL_INDEX_ADDR) &&
    (bank_select == DATA_BANK);
  assign sel_value = (eff_addr == CELL_VALUE_ADDR) &&
    (bank_select == DATA_BANK);
  // [RULE_02] Indirect only decode
  assign sel_control = via_port && (bank_select == CONTROL_BANK) &&
    (indirect_pointer_one == CELL_CONTROL_ADDR);
  assign ctrl_we = req_i.wr && sel_control;

  // [RULE_22] Ambiguous trigger pair
  assign both_trig = req_i.wdata[STORE_TRIG_BIT] &&
    req_i.wdata[FETCH_TRIG_BIT];
  // A new cycle starts only while both triggers read back zero
  assign trig_idle = !cell_control_reg[STORE_TRIG_BIT] &&
    !cell_control_reg[FETCH_TRIG_BIT];
  // [RULE_07] [RULE_10] Permit must already be set
  assign store_go = ctrl_we && req_i.wdata[STORE_TRIG_BIT] &&
    cell_control_reg[STORE_PERMIT_BIT] && !both_trig && trig_idle;
  // [RULE_12] [RULE_15] Permit must already be set
  assign fetch_go = ctrl_we && req_i.wdata[FETCH_TRIG_BIT] &&
    cell_control_reg[FETCH_PERMIT_BIT] && !both_trig && trig_idle;
  // One driver for the whole command word
  assign cell_cmd = {cell_index_reg, cell_value_reg};

  // Pointer, bank and index registers, written directly
  always_comb begin
    next_bank_select = bank_select;
    next_pointer = indirect_pointer_one;
    next_index = cell_index_reg;
    if (req_i.wr && sel_bank) begin
      next_bank_select = req_i.wdata[0];
    end
    if (req_i.wr && sel_pointer) begin
      next_pointer = req_i.wdata;
    end
    // [RULE_04] Only six index bits stored
    if (req_i.wr && sel_index) begin
      next_index = req_i.wdata[5:0];
    end
  end

  // Value register; a finished fetch takes priority over the core
  always_comb begin
    next_value = cell_value_reg;
    // [RULE_18] Fetched byte loaded and held
    if (fetch_done) begin
      next_value = fetch_data;
    // [RULE_05] Full byte write
    end else if (req_i.wr && sel_value) begin
      next_value = req_i.wdata;
    end
  end

  // Control register; software cannot clear a trigger early
  always_comb begin
    next_control = cell_control_reg;
    if (ctrl_we) begin
      next_control[STORE_PERMIT_BIT] = req_i.wdata[STORE_PERMIT_BIT];
      next_control[FETCH_PERMIT_BIT] = req_i.wdata[FETCH_PERMIT_BIT];
    end
    // [RULE_08] Write cycle start
    if (store_go) begin
      next_control[STORE_TRIG_BIT] = 1'b1;
    end
    // [RULE_13] Read cycle start
    if (fetch_go) begin
      next_control[FETCH_TRIG_BIT] = 1'b1;
    end
    // [RULE_09] Self clear on write end
    if (store_done) begin
      next_control[STORE_TRIG_BIT] = 1'b0;
    end
    // [RULE_14] Self clear on read end
    if (fetch_done) begin
      next_control[FETCH_TRIG_BIT] = 1'b0;
    end
  end

  // [RULE_21] Sticky done flag, set beats clear
  assign next_done_flag = (store_done || fetch_done) ||
    (nv_done_flag_o && !nv_done_clr_i);

  // Read data, registered; unmapped addresses answer zero
  always_comb begin
    next_rdata = rdata_o;
    if (req_i.rd) begin
      if (sel_index) begin
        next_rdata = {2'b00, cell_index_reg};
      end else if (sel_value) begin
        next_rdata = cell_value_reg;
      end else if (sel_control) begin
        next_rdata = {4'h0, cell_control_reg};
      end else if (sel_bank) begin
        next_rdata = {7'h00, bank_select};
      end else if (sel_pointer) begin
        next_rdata = indirect_pointer_one;
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bank_select <= BANK_RST;
      indirect_pointer_one <= PTR_RST;
      cell_index_reg <= INDEX_RST;
      cell_value_reg <= VALUE_RST;
      cell_control_reg <= CONTROL_RST;
      nv_done_flag_o <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      bank_select <= next_bank_select;
      indirect_pointer_one <= next_pointer;
      cell_index_reg <= next_index;
      cell_value_reg <= next_value;
      cell_control_reg <= next_control;
      nv_done_flag_o <= next_done_flag;
      rdata_o <= next_rdata;
    end
  end

  // [RULE_19] 64 cell array behind the registers
  eera_array #(
    .CELLS(CELL_COUNT),
    .TICK_DIV(TICK_DIV),
    .WRITE_TICKS(WRITE_TICKS),
    .READ_CYCLES(READ_TIME_CYCLES)
  ) u_array (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .fetch_go_i(fetch_go),
    .store_go_i(store_go),
    .cmd_i(cell_cmd),
    .fetch_done_o(fetch_done),
    .store_done_o(store_done),
    .fetch_data_o(fetch_data)
  );

  // Checks on the register behaviour
  index_top_zero_a: assert property ( // [RULE_04]
    @(posedge clock_i) disable iff (!rst_b_i)
    req_i.rd && sel_index |=> rdata_o[7:6] == 2'b00)
    else $error("index upper bits not zero");

  control_direct_a: assert property ( // [RULE_02]
    @(posedge clock_i) disable iff (!rst_b_i)
    req_i.wr && !via_port && req_i.addr == CELL_CONTROL_ADDR
    && !ctrl_we |=> $stable(cell_control_reg[STORE_PERMIT_BIT])
    && $stable(cell_control_reg[FETCH_PERMIT_BIT]))
    else $error("control changed by direct write");

  store_blocked_a: assert property ( // [RULE_07]
    @(posedge clock_i) disable iff (!rst_b_i)
    ctrl_we && !cell_control_reg[STORE_PERMIT_BIT] && trig_idle
    |=> !cell_control_reg[STORE_TRIG_BIT])
    else $error("write started without store permit");

  fetch_blocked_a: assert property ( // [RULE_12]
    @(posedge clock_i) disable iff (!rst_b_i)
    ctrl_we && !cell_control_reg[FETCH_PERMIT_BIT] && trig_idle
    |=> !cell_control_reg[FETCH_TRIG_BIT])
    else $error("read started without fetch permit");

  store_start_a: assert property ( // [RULE_08]
    @(posedge clock_i) disable iff (!rst_b_i)
    ctrl_we && trig_idle && cell_control_reg[STORE_PERMIT_BIT]
    && req_i.wdata[STORE_TRIG_BIT] && !req_i.wdata[FETCH_TRIG_BIT]
    |=> cell_control_reg[STORE_TRIG_BIT])
    else $error("permitted write did not start");

  fetch_end_a: assert property ( // [RULE_14]
    @(posedge clock_i) disable iff (!rst_b_i)
    ctrl_we && trig_idle && cell_control_reg[FETCH_PERMIT_BIT]
    && req_i.wdata[FETCH_TRIG_BIT] && !req_i.wdata[STORE_TRIG_BIT]
    |=> cell_control_reg[FETCH_TRIG_BIT] [*3] ##1
    !cell_control_reg[FETCH_TRIG_BIT])
    else $error("fetch trigger not cleared on time");

  both_ignored_a: assert property ( // [RULE_22]
    @(posedge clock_i) disable iff (!rst_b_i)
    ctrl_we && trig_idle && both_trig |=> trig_idle)
    else $error("trigger pair started a cycle");

  value_loaded_a: assert property ( // [RULE_18]
    @(posedge clock_i) disable iff (!rst_b_i)
    fetch_done |=> cell_value_reg == $past(fetch_data)
    && !cell_control_reg[FETCH_TRIG_BIT])
    else $error("fetched byte not in value register");

  done_sticky_a: assert property ( // [RULE_21]
    @(posedge clock_i) disable iff (!rst_b_i)
    nv_done_flag_o && !nv_done_clr_i |=> nv_done_flag_o)
    else $error("done flag lost");

  done_set_a: assert property ( // [RULE_21]
    @(posedge clock_i) disable iff (!rst_b_i)
    store_done || fetch_done |=> nv_done_flag_o)
    else $error("done flag not set at cycle end");

  done_clear_a: assert property ( // [RULE_21]
    @(posedge clock_i) disable iff (!rst_b_i)
    nv_done_clr_i && !store_done && !fetch_done |=> !nv_done_flag_o)
    else $error("done flag not cleared");

  store_clear_a: assert property ( // [RULE_09]
    @(posedge clock_i) disable iff (!rst_b_i)
    store_done |=> !cell_control_reg[STORE_TRIG_BIT])
    else $error("store trigger not cleared");
endmodule : eera_top

// file: eera_pkg.sv
// Shared constants and types for the EEPROM register front end
package eera_pkg;
  // Clock and timer figures
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMER_TICK_NS = 1000;
  localparam int TIMER_DIV_CYCLES = TIMER_TICK_NS / CLK_PERIOD_NS;
  localparam int WRITE_TIME_US = 20;
  localparam int WRITE_TIME_TICKS = WRITE_TIME_US * 1000 / TIMER_TICK_NS;
  localparam int READ_TIME_NS = 20;
  localparam int READ_TIME_CYCLES =
    (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Data memory addresses
  localparam logic [7:0] INDIRECT_PORT_ADDR = 8'h02;
  localparam logic [7:0] INDIRECT_PTR_ADDR = 8'h03;
  localparam logic [7:0] BANK_SEL_ADDR = 8'h04;
  localparam logic [7:0] CELL_INDEX_ADDR = 8'h1e;
  localparam logic [7:0] CELL_VALUE_ADDR = 8'h1f;
  localparam logic [7:0] CELL_CONTROL_ADDR = 8'h40;
  localparam logic DATA_BANK = 1'b0;
  localparam logic CONTROL_BANK = 1'b1;

  // Control field positions
  localparam int STORE_PERMIT_BIT = 3;
  localparam int STORE_TRIG_BIT = 2;
  localparam int FETCH_PERMIT_BIT = 1;
  localparam int FETCH_TRIG_BIT = 0;

  // Array geometry and reset values
  localparam int CELL_INDEX_W = 6;
  localparam int CELL_COUNT = 64;
  localparam logic [3:0] CONTROL_RST = 4'h0;
  localparam logic [5:0] INDEX_RST = 6'h00;
  localparam logic [7:0] VALUE_RST = 8'h00;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic BANK_RST = 1'b0;

  // One data memory access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eera_dm_req_t;

  // Location and byte handed to the array
  typedef struct packed {
    logic [CELL_INDEX_W-1:0] index;
    logic [7:0] data;
  } eera_cell_cmd_t;

  typedef enum logic [1:0] {
    EERA_IDLE,
    EERA_FETCHING,
    EERA_STORING
  } eera_state_t;
endpackage : eera_pkg

// file: eera_array.sv
// EEPROM cell array with its read sequencer and write timer
`timescale 1ns/1ps
module eera_array #(
  parameter int CELLS = eera_pkg::CELL_COUNT,
  parameter int TICK_DIV = eera_pkg::TIMER_DIV_CYCLES,
  parameter int WRITE_TICKS = eera_pkg::WRITE_TIME_TICKS,
  parameter int READ_CYCLES = eera_pkg::READ_TIME_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic fetch_go_i,
  input wire logic store_go_i,
  input wire eera_pkg::eera_cell_cmd_t cmd_i,
  output logic fetch_done_o,
  output logic store_done_o,
  output logic [7:0] fetch_data_o
);
  import eera_pkg::*;

  logic [7:0] mem [CELLS];
  eera_state_t state, next_state;
  logic [15:0] cnt, next_cnt;
  logic [15:0] div, next_div;
  eera_cell_cmd_t cmd, next_cmd;
  logic next_fetch_done, next_store_done;
  logic [7:0] next_fetch_data;
  logic tick, mem_we;

  // Free running timer base, unrelated to when a store starts
  assign tick = (div == 16'(TICK_DIV - 1));
  assign next_div = tick ? 16'h0000 : div + 16'h0001;

  // Sequencer: reads take fixed cycles, writes count timer ticks
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cmd = cmd;
    next_fetch_done = 1'b0;
    next_store_done = 1'b0;
    next_fetch_data = fetch_data_o;
    mem_we = 1'b0;
    case (state)
      EERA_IDLE: begin
        if (store_go_i) begin
          next_state = EERA_STORING;
          next_cnt = 16'(WRITE_TICKS);
          next_cmd = cmd_i;
        end else if (fetch_go_i) begin
          next_state = EERA_FETCHING;
          next_cnt = 16'(READ_CYCLES);
          next_cmd = cmd_i;
        end
      end
      EERA_FETCHING: begin
        next_cnt = cnt - 16'h0001;
        if (cnt <= 16'h0001) begin
          next_state = EERA_IDLE;
          next_fetch_done = 1'b1;
          next_fetch_data = mem[cmd.index];
        end
      end
      // [RULE_20] Timer paced write
      EERA_STORING: begin
        if (tick) begin
          next_cnt = cnt - 16'h0001;
          if (cnt <= 16'h0001) begin
            next_state = EERA_IDLE;
            next_store_done = 1'b1;
            mem_we = 1'b1;
          end
        end
      end
      default: next_state = EERA_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= EERA_IDLE;
      cnt <= 16'h0000;
      div <= 16'h0000;
      cmd <= '0;
      fetch_done_o <= 1'b0;
      store_done_o <= 1'b0;
      fetch_data_o <= 8'h00;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      div <= next_div;
      cmd <= next_cmd;
      fetch_done_o <= next_fetch_done;
      store_done_o <= next_store_done;
      fetch_data_o <= next_fetch_data;
    end
  end

  // Nonvolatile cells keep their contents through reset
  always_ff @(posedge clock_i) begin
    if (mem_we) begin
      mem[cmd.index] <= cmd.data;
    end
  end
endmodule : eera_array

// file: eera_core_model.sv
// CPU core model issuing data memory accesses to the front end
`timescale 1ns/1ps
module eera_core_model (
  input wire logic clock_i,
  input wire logic [7:0] rdata_i,
  output eera_pkg::eera_dm_req_t req_o
);
  import eera_pkg::*;

  // Bus idle from time zero
  initial begin
    req_o = '0;
  end

  // One write, launched after an edge and held until the taking edge
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req_o <= {1'b1, 1'b0, a, d};
    @(posedge clock_i);
    req_o <= '0;
  endtask : bus_wr

  // One read; data is registered at the taking edge, so look just after
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    req_o <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clock_i);
    req_o <= '0;
    #1;
    d = rdata_i;
  endtask : bus_rd

  // pointer and bank set first
  // Bank goes back to 0 afterwards so direct accesses stay in bank 0
  task automatic ctl_wr(input logic [7:0] d);
    bus_wr(INDIRECT_PTR_ADDR, CELL_CONTROL_ADDR);
    bus_wr(BANK_SEL_ADDR, 8'h01);
    bus_wr(INDIRECT_PORT_ADDR, d);
    bus_wr(BANK_SEL_ADDR, 8'h00);
  endtask : ctl_wr

  task automatic ctl_rd(output logic [7:0] d);
    bus_wr(INDIRECT_PTR_ADDR, CELL_CONTROL_ADDR);
    bus_wr(BANK_SEL_ADDR, 8'h01);
    bus_rd(INDIRECT_PORT_ADDR, d);
    bus_wr(BANK_SEL_ADDR, 8'h00);
  endtask : ctl_rd
endmodule : eera_core_model

// file: eera_top_tb.sv
// Self-checking bench for the EEPROM register front end
`timescale 1ns/1ps
module eera_top_tb;
  import eera_pkg::*;
  localparam int TDIV = 4;
  localparam int WTICKS = 3;
  logic clock_i = 1'b0;
  logic rst_b_i;
  logic nv_done_clr_i;
  eera_dm_req_t req;
  logic [7:0] rdata;
  logic nv_done_flag;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int t0;
  logic [7:0] rd_v;

  // 100 MHz system clock
  always #5 clock_i = ~clock_i;

  // Short timer so a store finishes in a few cycles
  eera_top #(.TICK_DIV(TDIV), .WRITE_TICKS(WTICKS)) u_eera_top (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .req_i(req),
    .nv_done_clr_i(nv_done_clr_i),
    .rdata_o(rdata),
    .nv_done_flag_o(nv_done_flag)
  );

  eera_core_model u_eera_core_model (
    .clock_i(clock_i),
    .rdata_i(rdata),
    .req_o(req)
  );

  // Cycle counter; a hang ends the run as a mismatch
  always @(posedge clock_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    u_eera_core_model.bus_rd(a, rd_v);
    chk("direct_read", exp, rd_v);
  endtask : rd_chk

  task automatic ctl_chk(input logic [7:0] exp);
    u_eera_core_model.ctl_rd(rd_v);
    chk("control_read", exp, rd_v);
  endtask : ctl_chk

  // Sample after the last edge's updates have landed
  task automatic flag_chk(input logic exp);
    #1;
    chk("done_flag", {7'h00, exp}, {7'h00, nv_done_flag});
  endtask : flag_chk

  // Software clear of the done flag
  task automatic clr_flag();
    @(posedge clock_i);
    nv_done_clr_i <= 1'b1;
    @(posedge clock_i);
    nv_done_clr_i <= 1'b0;
    flag_chk(1'b0);
  endtask : clr_flag

  // Poll a trigger bit under a bounded count
  task automatic wait_clear(input int b);
    int i;
    for (i = 0; i < 40; i++) begin
      u_eera_core_model.ctl_rd(rd_v);
      if (rd_v[b] === 1'b0) break;
    end
    chk("trigger_clear", 8'h00, {7'h00, rd_v[b]});
  endtask : wait_clear

  task automatic t_reset();
    rd_chk(CELL_INDEX_ADDR, 8'h00);
    rd_chk(CELL_VALUE_ADDR, 8'h00);
    ctl_chk(8'h00);
    flag_chk(1'b0);
  endtask : t_reset

  task automatic t_direct();
    u_eera_core_model.bus_wr(CELL_INDEX_ADDR, 8'hff);
    rd_chk(CELL_INDEX_ADDR, 8'h3f);
    u_eera_core_model.bus_wr(CELL_VALUE_ADDR, 8'ha5);
    rd_chk(CELL_VALUE_ADDR, 8'ha5);
    // Direct access at the control location must miss it
    u_eera_core_model.bus_wr(CELL_CONTROL_ADDR, 8'h0f);
    rd_chk(CELL_CONTROL_ADDR, 8'h00);
    ctl_chk(8'h00);
  endtask : t_direct

  task automatic t_blocked();
    u_eera_core_model.ctl_wr(8'h01);
    ctl_chk(8'h00);
    u_eera_core_model.ctl_wr(8'h04);
    ctl_chk(8'h00);
    // Permit and trigger in one write: trigger must be dropped
    u_eera_core_model.ctl_wr(8'h0c);
    ctl_chk(8'h08);
    flag_chk(1'b0);
    u_eera_core_model.ctl_wr(8'h00);
  endtask : t_blocked

  task automatic t_store();
    logic long_enough;
    u_eera_core_model.bus_wr(CELL_INDEX_ADDR, 8'h3f);
    u_eera_core_model.bus_wr(CELL_VALUE_ADDR, 8'h5a);
    u_eera_core_model.ctl_wr(8'h08);
    u_eera_core_model.ctl_wr(8'h0c);
    t0 = cyc;
    ctl_chk(8'h0c);
    wait_clear(STORE_TRIG_BIT);
    // Not done before the timer could have run out
    long_enough = (cyc - t0) >= (WTICKS - 1) * TDIV - 2;
    chk("store_time", 8'h01, {7'h00, long_enough});
    flag_chk(1'b1);
    rd_chk(CELL_VALUE_ADDR, 8'h5a);
    clr_flag();
    u_eera_core_model.ctl_wr(8'h00);
  endtask : t_store

  task automatic t_fetch();
    u_eera_core_model.bus_wr(CELL_VALUE_ADDR, 8'h00);
    u_eera_core_model.ctl_wr(8'h02);
    u_eera_core_model.ctl_wr(8'h03);
    wait_clear(FETCH_TRIG_BIT);
    rd_chk(CELL_VALUE_ADDR, 8'h5a);
    rd_chk(CELL_VALUE_ADDR, 8'h5a);
    flag_chk(1'b1);
    clr_flag();
  endtask : t_fetch

  task automatic t_both();
    u_eera_core_model.ctl_wr(8'h0a);
    u_eera_core_model.ctl_wr(8'h0f);
    ctl_chk(8'h0a);
    repeat (20) @(posedge clock_i);
    flag_chk(1'b0);
    u_eera_core_model.ctl_wr(8'h00);
  endtask : t_both

  // Reset for three cycles, then the scenarios in turn
  initial begin
    rst_b_i <= 1'b0;
    nv_done_clr_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_direct();
    t_blocked();
    t_store();
    t_fetch();
    t_both();
    stop_test();
  end
endmodule : eera_top_tb
